// *** lcd_drive_control_test.sv ***
// Register-level tests of the LCD drive control block
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module lcd_drive_control_test
    import lcddc_pkg::*;
;
    logic        clk, nrst, awv, wv, bry, arv, rry, lit, awr, wr_r, bv, arr;
    logic        rv, vsel, pwr, ce;
    logic [17:0] awa, ara;
    logic [15:0] base;
    logic [31:0] wd, rdat;
    logic [3:0]  ws, contrast;
    logic [1:0]  br, rr, duty, segm;
    int          error_cnt, tests_run;
    lcddc_top lcddc_top_inst (.clk(clk), .nrst(nrst), .ce(ce),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .duty_sel(duty),
        .regulated_voltage_select(vsel), .panel_power_on(pwr),
        .segment_mode(segm), .display_base(base), .contrast_level(contrast));
    lcddc_panel lcddc_panel_inst (.panel_power_on(pwr), .segment_mode(segm),
        .all_lit(lit));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ==========================================================
    // Bus tasks, called just after a rising edge
    // A handshake only counts while the clock enable is high
    task automatic wr(input logic [17:0] a, input logic [3:0] d, s,
                      input logic [1:0] e);
        awa <= a;
        wd  <= {28'h0, d};
        ws  <= s;
        awv <= 1'b1;
        wv  <= 1'b1;
        bry <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awr && ce) awv <= 1'b0;
            if (wr_r && ce) wv <= 1'b0;
        end while (!(bv && ce));
        `CHK(br, e)
    endtask
    task automatic rd(input logic [17:0] a, input logic [3:0] d,
                      input logic [1:0] e, input logic [27:0] h = 28'h0);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arr && ce) arv <= 1'b0;
        end while (!(rv && ce));
        `CHK(rdat, {h, d})
        `CHK(rr, e)
    endtask
    // Outputs lag the register by a cycle, so wait past it
    task automatic settle;
        repeat (2) @(posedge clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #(3000 * 50);
        error_cnt++;
        tally_and_finish;
    end
    // ==========================================================
    // Tests
    initial
    begin
        logic [2:0] i;
        {awv, wv, bry, arv, rry, nrst} = 6'h0;
        {awa, ara, wd, ws} = 72'h0;
        ce = 1'b1;
        error_cnt = 0;
        tests_run = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        rd(LCDDC_ADDR_DUTY_POWER, 4'h0, LCDDC_RESP_OKAY);
        rd(LCDDC_ADDR_MODE, 4'h4, LCDDC_RESP_OKAY);
        rd(LCDDC_ADDR_CONTRAST, 4'h0, LCDDC_RESP_OKAY);
        `CHK(segm, 2'h2)
        $display("reset test done");
        for (i = 3'h0; i < 3'h4; i++)
        begin
            wr(LCDDC_ADDR_DUTY_POWER, {i[1:0], i[0], ~i[0]}, 4'h1, 2'h0);
            settle;
            `CHK(duty, i[1] ? 2'h2 : i[1:0])
            `CHK(vsel, i[0])
            rd(LCDDC_ADDR_DUTY_POWER, {i[1:0], i[0], ~i[0]}, 2'h0);
        end
        $display("duty test done");
        wr(LCDDC_ADDR_MODE, 4'h9, 4'h1, 2'h0);
        settle;
        `CHK(base, 16'hf100)
        wr(LCDDC_ADDR_DUTY_POWER, 4'h5, 4'h1, 2'h0);
        settle;
        `CHK(base, 16'hf000)
        rd(LCDDC_ADDR_MODE, 4'h9, 2'h0);
        $display("page test done");
        for (i = 3'h0; i < 3'h4; i++)
        begin
            wr(LCDDC_ADDR_MODE, {1'b0, i[1:0], 1'b0}, 4'h1, 2'h0);
            settle;
            `CHK(segm, i[1] ? 2'h2 : {1'b0, i[0]})
            `CHK(lit, i == 3'h1)
        end
        $display("segment test done");
        wr(LCDDC_ADDR_CONTRAST, 4'hf, 4'h1, 2'h0);
        wr(LCDDC_ADDR_CONTRAST, 4'h3, 4'h0, 2'h0);
        wr(18'h3fe00, 4'h5, 4'h1, LCDDC_RESP_SLVERR);
        settle;
        `CHK(contrast, 4'hf)
        rd(18'h3fe00, 4'h0, LCDDC_RESP_SLVERR);
        $display("refusal test done");
        // 1/16 duty, all off, first page
        rd(LCDDC_ADDR_STATUS, 4'h9, 2'h0, 28'h000f000);
        $display("status test done");
        // Enable low must hold off the bus and freeze the contrast register
        ce <= 1'b0;
        fork
            wr(LCDDC_ADDR_CONTRAST, 4'h6, 4'h1, 2'h0);
            begin
                repeat (6) @(posedge clk);
                `CHK(contrast, 4'hf)
                `CHK(bv, 1'b0)
                ce <= 1'b1;
            end
        join
        settle;
        `CHK(contrast, 4'h6)
        $display("enable test done");
        tally_and_finish;
    end
endmodule // lcd_drive_control_test

// *** lcddc_checker_assertions.sv ***
// Checker of the LCD drive control outputs against register writes
`timescale 1ns/10ps
module lcddc_checker
    import lcddc_pkg::*;
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        ce,
    input wire logic [17:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  duty_sel,
    input wire logic        regulated_voltage_select,
    input wire logic [1:0]  segment_mode,
    input wire logic [15:0] display_base
);
    // ==========================================================
    // Write capture
    logic [3:0] wd_q;
    wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                 && s_axi_wready && ce && s_axi_wstrb[0];
    wire to_dp = wr_hs && s_axi_awaddr == LCDDC_ADDR_DUTY_POWER;
    wire to_md = wr_hs && s_axi_awaddr == LCDDC_ADDR_MODE;
    // One write outstanding, so the captured word stays valid
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            wd_q <= 4'h0;
        else if (wr_hs)
            wd_q <= s_axi_wdata[3:0];
    // ==========================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    duty_code_a: assert property (to_dp |=> ##[1:2]
        duty_sel == (wd_q[3] ? 2'h2 : wd_q[3:2])) else $error("duty bad");
    volt_sel_a: assert property (to_dp |=> ##[1:2]
        regulated_voltage_select == wd_q[1]) else $error("vsel bad");
    page_base_a: assert property (
        to_md && duty_sel == LCDDC_DUTY_8 |=> ##[1:2]
        display_base == (wd_q[0] ? LCDDC_PAGE1_BASE : LCDDC_PAGE0_BASE))
        else $error("page base wrong");
    page_store_a: assert property (duty_sel != 2'h2 |->
        display_base == 16'hf000) else $error("page bit leaked");
    seg_mode_a: assert property (to_md |=> ##[1:2]
        segment_mode == (wd_q[2] ? 2'h2 : {1'b0, wd_q[1]})) else $error("seg");
endmodule // lcddc_checker

bind lcddc_top lcddc_checker lcddc_checker_inst (.clk(clk), .nrst(nrst),
    .ce(ce), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .duty_sel(duty_sel),
    .regulated_voltage_select(regulated_voltage_select),
    .segment_mode(segment_mode), .display_base(display_base));

// *** lcddc_decode.sv ***
// Decoder from control fields to drive duty, display mode and memory page
`timescale 1ns/10ps
module lcddc_decode
    import lcddc_pkg::*;
(
    input  wire logic [1:0]  duty_code,
    input  wire logic        display_page_select,
    input  wire logic        all_segments_on,
    input  wire logic        all_segments_off,
    output lcddc_duty_e      duty_mode,
    output lcddc_show_e      show_mode,
    output logic [15:0]      mem_base
);
    // ==========================================================
    // Decoding
    // Codes 2 and 3 fold together
    assign duty_mode = duty_code[1] ? LCDDC_DUTY_8 :
                       (duty_code[0] ? LCDDC_DUTY_16 : LCDDC_DUTY_17); // [R01]
    // Page only matters at 1/8 duty
    assign mem_base  = (duty_mode == LCDDC_DUTY_8 && display_page_select) ?
                       LCDDC_PAGE1_BASE : LCDDC_PAGE0_BASE; // [R03] [R04]
    // Blanking beats lighting, so the reset state is dark
    assign show_mode = all_segments_off ? LCDDC_SHOW_OFF :
                       (all_segments_on ? LCDDC_SHOW_ON
                                        : LCDDC_SHOW_NORMAL); // [R05]
endmodule // lcddc_decode

// *** lcddc_panel.sv ***
// Behavioural panel model on the panel power and segment drive
`timescale 1ns/10ps
module lcddc_panel
    import lcddc_pkg::*;
(
    input  wire logic       panel_power_on,
    input  wire logic [1:0] segment_mode,
    output logic            all_lit
);
    // Unpowered glass shows nothing whatever the drive asks for
    assign all_lit = panel_power_on && segment_mode == LCDDC_SHOW_ON;
endmodule // lcddc_panel

// *** lcddc_pkg.sv ***
// Package of register map, field positions and codes for the LCD drive control
package lcddc_pkg;
    // ==========================================================
    // Register indices, one aligned word each
    localparam logic [15:0] LCDDC_IDX_DUTY_POWER = 16'hff60;
    localparam logic [15:0] LCDDC_IDX_MODE       = 16'hff61;
    localparam logic [15:0] LCDDC_IDX_CONTRAST   = 16'hff62;
    localparam logic [15:0] LCDDC_IDX_STATUS     = 16'hff64;
    // Byte addresses are four times the index
    localparam logic [17:0] LCDDC_ADDR_DUTY_POWER =
        {LCDDC_IDX_DUTY_POWER, 2'b00};
    localparam logic [17:0] LCDDC_ADDR_MODE =
        {LCDDC_IDX_MODE, 2'b00};
    localparam logic [17:0] LCDDC_ADDR_CONTRAST =
        {LCDDC_IDX_CONTRAST, 2'b00};
    localparam logic [17:0] LCDDC_ADDR_STATUS =
        {LCDDC_IDX_STATUS, 2'b00};
    localparam logic [15:0] LCDDC_ADDR_MASK       = 16'hfffc;
    // ==========================================================
    // Field positions, duty power register
    localparam int LCDDC_POS_POWER   = 0;
    localparam int LCDDC_POS_VSEL    = 1;
    localparam int LCDDC_POS_DUTY_LO = 2;
    localparam int LCDDC_POS_DUTY_HI = 3;
    // Field positions, mode register
    localparam int LCDDC_POS_PAGE    = 0;
    localparam int LCDDC_POS_ALL_ON  = 1;
    localparam int LCDDC_POS_ALL_OFF = 2;
    localparam int LCDDC_POS_SPARE   = 3;
    // ==========================================================
    // Reset values
    localparam logic [3:0] LCDDC_RST_DUTY_POWER = 4'h0;
    localparam logic [3:0] LCDDC_RST_MODE       = 4'h4;
    localparam logic [3:0] LCDDC_RST_CONTRAST   = 4'h0;
    // ==========================================================
    // Display memory base addresses
    localparam logic [15:0] LCDDC_PAGE0_BASE = 16'hf000;
    localparam logic [15:0] LCDDC_PAGE1_BASE = 16'hf100;
    // AXI responses
    localparam logic [1:0] LCDDC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] LCDDC_RESP_SLVERR = 2'h2;
    // ==========================================================
    // Duty modes
    typedef enum logic [1:0] {
        LCDDC_DUTY_17 = 2'b00,
        LCDDC_DUTY_16 = 2'b01,
        LCDDC_DUTY_8  = 2'b10
    } lcddc_duty_e;
    // Segment display modes
    typedef enum logic [1:0] {
        LCDDC_SHOW_NORMAL = 2'b00,
        LCDDC_SHOW_ON     = 2'b01,
        LCDDC_SHOW_OFF    = 2'b10
    } lcddc_show_e;
endpackage

// *** lcddc_top.sv ***
// AXI4-Lite register block steering the LCD drive control outputs
`timescale 1ns/10ps
// Summary of operation
// [R01] Two-bit code picks 1/17, 1/16, 1/8 duty
// [R02] One bit picks second or first regulated level
// [R03] At 1/8 duty page bit picks memory range
// [R04] Otherwise page bit is plain storage
// [R05] All-off blanks, all-on lights, else normal
module lcddc_top
    import lcddc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic [17:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [17:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [1:0]       duty_sel,
    output logic             regulated_voltage_select,
    output logic             panel_power_on,
    output logic [1:0]       segment_mode,
    output logic [15:0]      display_base,
    output logic [3:0]       contrast_level
);
    // ==========================================================
    // Reset synchroniser
    logic       rst_meta;
    logic       rst_n;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ==========================================================
    // Registers
    logic [3:0]  duty_power;
    logic [3:0]  mode;
    logic [3:0]  contrast;
    logic [17:0] aw_addr;
    logic        aw_held;
    logic [3:0]  w_data;
    logic        w_strb0;
    logic        w_held;

    function automatic logic addr_ok(input logic [17:0] a);
        addr_ok = (a == LCDDC_ADDR_DUTY_POWER) || (a == LCDDC_ADDR_MODE) ||
                  (a == LCDDC_ADDR_CONTRAST);
    endfunction

    // ==========================================================
    // Write channel
    // Byte address is four times the index; lane 0 low nibble is the data
    wire        aw_take  = s_axi_awvalid && s_axi_awready;
    wire        w_take   = s_axi_wvalid && s_axi_wready;
    wire        wr_go    = aw_held && w_held && !s_axi_bvalid;
    wire        wr_hit   = addr_ok(aw_addr);
    wire        wr_en    = wr_go && wr_hit && w_strb0;
    wire        wr_dp    = wr_en && (aw_addr == LCDDC_ADDR_DUTY_POWER);
    wire        wr_md    = wr_en && (aw_addr == LCDDC_ADDR_MODE);
    wire        wr_ct    = wr_en && (aw_addr == LCDDC_ADDR_CONTRAST);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held       <= 1'b0;
            aw_addr       <= 18'h00000;
            w_held        <= 1'b0;
            w_data        <= 4'h0;
            w_strb0       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= LCDDC_RESP_OKAY;
        end
        else if (ce)
        begin
            s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
            s_axi_wready  <= !w_held && !w_take && !s_axi_bvalid;
            if (aw_take)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_held  <= 1'b1;
                w_data  <= s_axi_wdata[3:0];
                w_strb0 <= s_axi_wstrb[0];
            end
            if (wr_go)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? LCDDC_RESP_OKAY : LCDDC_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            duty_power <= LCDDC_RST_DUTY_POWER; // [R02]
            mode       <= LCDDC_RST_MODE; // [R05]
            contrast   <= LCDDC_RST_CONTRAST;
        end
        else if (ce)
        begin
            if (wr_dp)
                duty_power <= w_data; // [R01] [R02]
            if (wr_md)
                mode <= w_data; // [R04]
            if (wr_ct)
                contrast <= w_data;
        end
    end

    // ==========================================================
    // Read channel
    // Status word shows the decoded drive state the panel sees
    lcddc_duty_e duty_mode;
    lcddc_show_e show_mode;
    logic [15:0] mem_base;
    wire  [3:0]  rd_nib =
        (s_axi_araddr == LCDDC_ADDR_DUTY_POWER) ? duty_power :
        (s_axi_araddr == LCDDC_ADDR_MODE)       ? mode :
        (s_axi_araddr == LCDDC_ADDR_CONTRAST)   ? contrast : 4'h0;
    wire         rd_status = (s_axi_araddr == LCDDC_ADDR_STATUS);
    wire  [31:0] rd_word = rd_status ?
        {12'h000, mem_base, show_mode, duty_mode} : {28'h0000000, rd_nib};
    wire         rd_ok = addr_ok(s_axi_araddr) || rd_status;
    wire         ar_take = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= LCDDC_RESP_OKAY;
        end
        else if (ce)
        begin
            s_axi_arready <= !s_axi_rvalid && !ar_take;
            if (ar_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? LCDDC_RESP_OKAY : LCDDC_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Decode and panel outputs
    lcddc_decode lcddc_decode_inst (
        .duty_code           (duty_power[LCDDC_POS_DUTY_HI:LCDDC_POS_DUTY_LO]),
        .display_page_select (mode[LCDDC_POS_PAGE]),
        .all_segments_on     (mode[LCDDC_POS_ALL_ON]),
        .all_segments_off    (mode[LCDDC_POS_ALL_OFF]),
        .duty_mode           (duty_mode),
        .show_mode           (show_mode),
        .mem_base            (mem_base)
    );

    // Registered so the panel sees one clean change per write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            duty_sel                 <= LCDDC_DUTY_17;
            regulated_voltage_select <= 1'b0;
            panel_power_on           <= 1'b0;
            segment_mode             <= LCDDC_SHOW_OFF;
            display_base             <= LCDDC_PAGE0_BASE;
            contrast_level           <= LCDDC_RST_CONTRAST;
        end
        else if (ce)
        begin
            duty_sel                 <= duty_mode; // [R01]
            regulated_voltage_select <= duty_power[LCDDC_POS_VSEL]; // [R02]
            panel_power_on           <= duty_power[LCDDC_POS_POWER];
            segment_mode             <= show_mode; // [R05]
            display_base             <= mem_base; // [R03]
            contrast_level           <= contrast;
        end
    end
endmodule // lcddc_top
